// File: clsp_fb_scale.sv
// Converts a raw 8-bit feedback sample into a signed speed value.
`timescale 1ns/1ps
`include "clsp_map.svh"
module clsp_fb_scale
  import clsp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] raw,
  output logic signed [7:0] speed
);
  typedef struct packed {
    logic signed [7:0] speed;
  } clsp_fbs_t;

  clsp_fbs_t st;
  clsp_fbs_t next_st;
  logic signed [8:0] diff;

  always_comb begin
    next_st = st;
    // Mid-scale reads zero; ends saturate at plus and minus full scale.
    diff = $signed({1'b0, raw}) - $signed({1'b0, `CLSP_ADC_MID});
    if (diff > 9'sd127) begin
      next_st.speed = 8'sd127;
    end else if (diff < -9'sd127) begin
      next_st.speed = -8'sd127;
    end else begin
      next_st.speed = diff[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign speed = st.speed;
endmodule : clsp_fb_scale

// File: clsp_map.svh
// Register offsets, field positions, reset values and timing counts of the speed regulator.
`ifndef CLSP_MAP_SVH
`define CLSP_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CLSP_CTRL_OFS 12'h000
`define CLSP_GAIN_OFS 12'h004
`define CLSP_CMD_OFS 12'h008
`define CLSP_SPD_OFS 12'h00c
`define CLSP_PWR_OFS 12'h010

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define CLSP_CTRL_EN_BIT 0
`define CLSP_CTRL_OPEN_BIT 1
`define CLSP_CTRL_FBSEL_BIT 2
`define CLSP_CTRL_MODE_LSB 4
`define CLSP_CTRL_RST 32'h0000_0000
`define CLSP_GAIN_RST 32'h0000_0000

// ----------------------------------------------------------------------------
// Timing and scale
// ----------------------------------------------------------------------------
`define CLSP_LOOP_MS 16
`define CLSP_CLK_MHZ 100
`define CLSP_LOOP_CYC (`CLSP_LOOP_MS * 1000 * `CLSP_CLK_MHZ)
`define CLSP_FULL_POS 127
`define CLSP_ADC_MID 8'h80

`endif

// File: clsp_motor_model.sv
// Speed sensor model of both motors: tachometer voltage code and encoder speed.
`timescale 1ns/1ps
module clsp_motor_model
  import clsp_pkg::*;
(
  input wire logic pclk,
  input wire logic signed [7:0] speed_a,
  input wire logic signed [7:0] speed_b,
  output logic [7:0] ana_a,
  output logic [7:0] ana_b,
  output logic signed [7:0] enc_a,
  output logic signed [7:0] enc_b
);
  clsp_pair_t spd;
  always_ff @(posedge pclk) begin
    spd <= '{speed_a, speed_b};
  end
  // A stopped tachometer sits at mid-scale; full reverse reads near zero volts.
  assign ana_a = 8'(spd.a) ^ 8'h80;
  assign ana_b = 8'(spd.b) ^ 8'h80;
  assign enc_a = spd.a;
  assign enc_b = spd.b;
endmodule : clsp_motor_model

// File: clsp_pid_core.sv
// One PID evaluation: error, difference, accumulation and clamped sum.
`timescale 1ns/1ps
`include "clsp_map.svh"
module clsp_pid_core
  import clsp_pkg::*;
#(
  parameter int ACC_W = 16
)
(
  input wire logic signed [7:0] cmd,
  input wire logic signed [7:0] meas,
  input wire logic signed [8:0] prev_err,
  input wire logic signed [ACC_W-1:0] acc_in,
  input wire clsp_gain_t gain,
  output logic signed [8:0] err,
  output logic signed [ACC_W-1:0] acc_out,
  output logic signed [7:0] power
);
  function automatic logic signed [7:0] clsp_clamp(input logic signed [31:0] v);
    if (v > 32'sd127) begin
      return 8'sd127;
    end else if (v < -32'sd127) begin
      return -8'sd127;
    end
    return v[7:0];
  endfunction : clsp_clamp

  logic signed [31:0] acc_ext;
  logic signed [31:0] sum;
  logic signed [31:0] acc_max;

  always_comb begin
    acc_max = (32'sd1 <<< (ACC_W - 1)) - 32'sd1;
    err = 9'(cmd - meas);
    acc_ext = 32'(acc_in) + 32'(err);
    // Accumulator saturates so a stuck feedback drives power to full, never wraps.
    if (acc_ext > acc_max) begin
      acc_ext = acc_max;
    end else if (acc_ext < -acc_max) begin
      acc_ext = -acc_max;
    end
    acc_out = acc_ext[ACC_W-1:0];
    // Gains are in 1/16 units for the P and D terms, 1/256 for I.
    sum = ((32'(err) * 32'(gain.kp)) >>> 4)
        + ((acc_ext * 32'(gain.ki)) >>> 8)
        + ((32'(err - prev_err) * 32'(gain.kd)) >>> 4);
    power = clsp_clamp(sum);
  end
endmodule : clsp_pid_core

// File: clsp_pkg.sv
// Types shared by the speed regulator files.
package clsp_pkg;
  typedef enum logic [1:0] {
    CLSP_SEPARATE,
    CLSP_MIXED,
    CLSP_SPEED_POS
  } clsp_mode_t;

  typedef struct packed {
    logic signed [7:0] kp;
    logic signed [7:0] ki;
    logic signed [7:0] kd;
  } clsp_gain_t;

  typedef struct packed {
    logic signed [7:0] a;
    logic signed [7:0] b;
  } clsp_pair_t;

  typedef enum logic [1:0] {
    CLSP_IDLE,
    CLSP_CH_A,
    CLSP_CH_B
  } clsp_phase_t;
endpackage : clsp_pkg

// File: clsp_speed_loop.sv
// Two-channel closed-loop speed regulator with an APB register slave.
//
// Functional notes
// - Every 16 ms sample speed and subtract it from command forming signed error.
// - Proportional term is error times a programmable proportional gain.
// - Differential term is error change since last period times differential gain.
// - Integral term is running error sum times integral gain.
// - Mid-scale analog feedback reads as speed zero.
// - Analog feedback maps linearly from -127 at zero volts to +127 at full.
// - One gain set serves both channels.
// - Persistent shortfall raises power through the integrator until full output.
// - Emergency stop removes drive regardless of regulator state.
// - Open loop drives power straight from command yet still reports speed.
// - Mode setting picks separate, mixed, or speed-plus-position configuration.
`timescale 1ns/1ps
`include "clsp_map.svh"
module clsp_speed_loop
  import clsp_pkg::*;
#(
  parameter int LOOP_CYC = `CLSP_LOOP_CYC,
  parameter int ACC_W = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] ana_a,
  input wire logic [7:0] ana_b,
  input wire logic signed [7:0] enc_a,
  input wire logic signed [7:0] enc_b,
  input wire logic estop,
  output logic signed [7:0] power_a,
  output logic signed [7:0] power_b,
  output logic drive_en,
  output logic loop_tick
);
  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    clsp_gain_t gain;
    clsp_pair_t cmd;
    clsp_pair_t pwr;
    clsp_pair_t spd;
    logic signed [8:0] err_a;
    logic signed [8:0] err_b;
    logic signed [ACC_W-1:0] acc_a;
    logic signed [ACC_W-1:0] acc_b;
    logic [31:0] cnt;
    clsp_phase_t phase;
    logic tick;
    logic [31:0] rdata;
  } clsp_state_t;

  clsp_state_t st;
  clsp_state_t next_st;

  logic signed [7:0] ana_spd_a;
  logic signed [7:0] ana_spd_b;
  logic signed [7:0] meas_a;
  logic signed [7:0] meas_b;
  logic signed [7:0] cmd_eff_a;
  logic signed [7:0] cmd_eff_b;
  logic signed [7:0] core_cmd;
  logic signed [7:0] core_meas;
  logic signed [8:0] core_prev;
  logic signed [ACC_W-1:0] core_acc;
  logic signed [8:0] core_err;
  logic signed [ACC_W-1:0] core_acc_out;
  logic signed [7:0] core_pwr;
  clsp_mode_t mode;
  logic loop_en;
  logic open_loop;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  // --------------------------------------------------------------------------
  // Feedback scaling
  // --------------------------------------------------------------------------
  clsp_fb_scale u_fb_a (
    .pclk(pclk),
    .presetn(presetn),
    .raw(ana_a),
    .speed(ana_spd_a)
  );

  clsp_fb_scale u_fb_b (
    .pclk(pclk),
    .presetn(presetn),
    .raw(ana_b),
    .speed(ana_spd_b)
  );

  // --------------------------------------------------------------------------
  // Shared PID arithmetic, used for channel A then B in successive cycles
  // --------------------------------------------------------------------------
  clsp_pid_core #(
    .ACC_W(ACC_W)
  ) u_core (
    .cmd(core_cmd),
    .meas(core_meas),
    .prev_err(core_prev),
    .acc_in(core_acc),
    .gain(st.gain),
    .err(core_err),
    .acc_out(core_acc_out),
    .power(core_pwr)
  );

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  function automatic logic signed [7:0] clsp_sat8(input logic signed [8:0] v);
    if (v > 9'sd127) begin
      return 8'sd127;
    end else if (v < -9'sd127) begin
      return -8'sd127;
    end
    return v[7:0];
  endfunction : clsp_sat8

  // A raw command of -128 has no forward mirror, so it is held to -127 like every other output.
  function automatic logic signed [7:0] clsp_cmd_limit(input logic signed [7:0] c);
    if (c == 8'sh80) begin
      return -8'sd127;
    end
    return c;
  endfunction : clsp_cmd_limit

  // Code 3 is unused and falls back to separate channels.
  function automatic clsp_mode_t clsp_mode_of(input logic [1:0] code);
    unique case (code)
      2'h1: return CLSP_MIXED;
      2'h2: return CLSP_SPEED_POS;
      default: return CLSP_SEPARATE;
    endcase
  endfunction : clsp_mode_of

  // --------------------------------------------------------------------------
  // Command and feedback selection
  // --------------------------------------------------------------------------
  always_comb begin
    loop_en = st.ctrl[`CLSP_CTRL_EN_BIT];
    open_loop = st.ctrl[`CLSP_CTRL_OPEN_BIT];
    mode = clsp_mode_of(st.ctrl[`CLSP_CTRL_MODE_LSB +: 2]);
    meas_a = st.ctrl[`CLSP_CTRL_FBSEL_BIT] ? enc_a : ana_spd_a;
    meas_b = st.ctrl[`CLSP_CTRL_FBSEL_BIT] ? enc_b : ana_spd_b;
    // Mixed mode turns the two commands into throttle plus and minus steering.
    if (mode == CLSP_MIXED) begin
      cmd_eff_a = clsp_sat8(9'(st.cmd.a) + 9'(st.cmd.b));
      cmd_eff_b = clsp_sat8(9'(st.cmd.a) - 9'(st.cmd.b));
    end else begin
      cmd_eff_a = clsp_cmd_limit(st.cmd.a);
      cmd_eff_b = clsp_cmd_limit(st.cmd.b);
    end
  end

  // --------------------------------------------------------------------------
  // Shared core input selection
  // --------------------------------------------------------------------------
  always_comb begin
    if (st.phase == CLSP_CH_B) begin
      core_cmd = cmd_eff_b;
      core_meas = meas_b;
      core_prev = st.err_b;
      core_acc = st.acc_b;
    end else begin
      core_cmd = cmd_eff_a;
      core_meas = meas_a;
      core_prev = st.err_a;
      core_acc = st.acc_a;
    end
  end

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  always_comb begin
    unique case (paddr)
      `CLSP_CTRL_OFS, `CLSP_GAIN_OFS, `CLSP_CMD_OFS, `CLSP_SPD_OFS, `CLSP_PWR_OFS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    // Feedback is always reported, including in open loop, for monitoring.
    next_st.spd.a = meas_a;
    next_st.spd.b = meas_b;
    // ------------------------------------------------------------------------
    // Loop timing
    // ------------------------------------------------------------------------
    // The period must span at least three cycles, or a tick would land on a channel phase and be lost.
    if (st.cnt >= 32'(LOOP_CYC - 1)) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
      next_st.phase = CLSP_CH_A;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
    // ------------------------------------------------------------------------
    // Channel updates
    // ------------------------------------------------------------------------
    unique case (st.phase)
      CLSP_IDLE: begin
      end
      CLSP_CH_A: begin
        next_st.phase = CLSP_CH_B;
        if (loop_en && !open_loop && !estop) begin
          next_st.err_a = core_err;
          next_st.acc_a = core_acc_out;
          next_st.pwr.a = core_pwr;
        end
      end
      CLSP_CH_B: begin
        next_st.phase = CLSP_IDLE;
        // The same gain register feeds the shared core for both channels.
        if (loop_en && !open_loop && !estop) begin
          next_st.err_b = core_err;
          next_st.acc_b = core_acc_out;
          next_st.pwr.b = core_pwr;
        end
        // In this configuration channel B power is taken straight from its command, bypassing the PID core.
        if (mode == CLSP_SPEED_POS) begin
          next_st.pwr.b = clsp_cmd_limit(st.cmd.b);
          next_st.acc_b = '0;
          next_st.err_b = '0;
        end
      end
    endcase
    if (open_loop) begin
      next_st.pwr.a = cmd_eff_a;
      next_st.pwr.b = cmd_eff_b;
    end
    // Stopping also clears the integrators so drive does not leap back on release.
    if (estop || !loop_en) begin
      next_st.pwr = '0;
      next_st.acc_a = '0;
      next_st.acc_b = '0;
      next_st.err_a = '0;
      next_st.err_b = '0;
    end
    // ------------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------------
    if (wr_en) begin
      unique case (paddr)
        `CLSP_CTRL_OFS: next_st.ctrl = pwdata & 32'h0000_0037;
        `CLSP_GAIN_OFS: next_st.gain = pwdata[23:0];
        `CLSP_CMD_OFS: next_st.cmd = pwdata[15:0];
        default: begin
        end
      endcase
    end
    if (rd_en) begin
      unique case (paddr)
        `CLSP_CTRL_OFS: next_st.rdata = st.ctrl;
        `CLSP_GAIN_OFS: next_st.rdata = {8'h00, st.gain};
        `CLSP_CMD_OFS: next_st.rdata = {16'h0000, st.cmd};
        `CLSP_SPD_OFS: next_st.rdata = {16'h0000, st.spd};
        `CLSP_PWR_OFS: next_st.rdata = {15'h0000, estop, st.pwr};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.ctrl <= `CLSP_CTRL_RST;
      st.gain <= 24'(`CLSP_GAIN_RST);
      st.phase <= CLSP_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = st.rdata;
  // Gated combinationally too, so stop acts in the very cycle it is raised.
  assign power_a = estop ? 8'sd0 : st.pwr.a;
  assign power_b = estop ? 8'sd0 : st.pwr.b;
  assign drive_en = ~estop & loop_en;
  assign loop_tick = st.tick;
endmodule : clsp_speed_loop

// File: clsp_speed_loop_assertions.sv
// Concurrent checks on the speed regulator ports.
`timescale 1ns/1ps
module clsp_speed_loop_assertions #(
  parameter int LOOP_CYC = 20
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic estop,
  input wire logic signed [7:0] power_a,
  input wire logic signed [7:0] power_b,
  input wire logic drive_en,
  input wire logic loop_tick
);
  int cnt;
  logic seen;
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      seen <= 1'b0;
    end else if (loop_tick) begin
      cnt <= 0;
      seen <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence tick_s;
    loop_tick;
  endsequence
  // Outputs may also move after a register write or an enable change, so those cycles are excluded.
  sequence calm_s;
    drive_en && $past(drive_en) && !$past(estop) && !$past(wr_acc) && !$past(wr_acc, 2);
  endsequence
  tick_pulse_a: assert property (tick_s |=> !loop_tick)
    else $error("tick longer than one cycle");
  tick_period_a: assert property (loop_tick && seen |-> cnt == LOOP_CYC - 1)
    else $error("loop period wrong");
  tick_due_a: assert property (cnt <= LOOP_CYC)
    else $error("loop tick missing");
  estop_off_a: assert property (estop |-> power_a == 8'sd0 && power_b == 8'sd0 && !drive_en)
    else $error("drive present during stop");
  drive_off_a: assert property (!drive_en |-> power_a == 8'sd0 && power_b == 8'sd0)
    else $error("power without drive enable");
  power_range_a: assert property (power_a != -8'sd128 && power_b != -8'sd128)
    else $error("power beyond full scale");
  a_update_a: assert property (calm_s ##0 $changed(power_a) |-> $past(loop_tick) || $past(loop_tick, 2))
    else $error("power a changed off tick");
  b_update_a: assert property (calm_s ##0 $changed(power_b) |-> $past(loop_tick, 2) || $past(loop_tick, 3))
    else $error("power b changed off tick");
  apb_error_a: assert property (psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 12'h010))
    else $error("bus error flag wrong");
endmodule : clsp_speed_loop_assertions
bind clsp_speed_loop clsp_speed_loop_assertions #(.LOOP_CYC(LOOP_CYC)) chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr), .estop(estop),
  .power_a(power_a), .power_b(power_b), .drive_en(drive_en), .loop_tick(loop_tick));

// File: tb_top.sv
// Self-checking bench for the speed regulator.
`timescale 1ns/1ps
`include "clsp_map.svh"
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, estop = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, drive_en, loop_tick;
  logic signed [7:0] power_a, power_b, enc_a, enc_b, fa = 0, fb = 0;
  logic [7:0] ana_a, ana_b;
  logic [32:0] exp_q[$];
  logic [15:0] mexp[3] = '{16'h1e0a, 16'h2814, 16'h1e0a};
  logic [15:0] cexp[3] = '{16'h1903, 16'h230d, 16'h190a};
  int sv[3] = '{127, -127, 0};
  int failures = 0, compares = 0, cmd, sp;
  clsp_speed_loop #(.LOOP_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ana_a(ana_a), .ana_b(ana_b), .enc_a(enc_a), .enc_b(enc_b), .estop(estop), .power_a(power_a),
    .power_b(power_b), .drive_en(drive_en), .loop_tick(loop_tick));
  clsp_motor_model motor (.pclk(pclk), .speed_a(fa), .speed_b(fb), .ana_a(ana_a), .ana_b(ana_b),
    .enc_a(enc_a), .enc_b(enc_b));
  initial begin
    forever #5 pclk = ~pclk;
  end
  task automatic stop_test;
    if (exp_q.size() != 0) begin
      failures++;
      $display("BAD pending reads expected %0d seen %0d", 0, exp_q.size());
    end
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic check(string what, logic [32:0] exp, logic [32:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Only the access-phase edge with pready high completes a transfer.
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      failures++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(logic [11:0] a, logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic ticks(int k);
    int n = 0;
    while (k > 0) begin
      @(posedge pclk);
      n++;
      if (loop_tick === 1'b1) k--;
      if (n > 2000) begin
        failures++;
        stop_test();
      end
    end
    repeat (4) @(posedge pclk);
  endtask : ticks
  function automatic logic [32:0] pair(int a, int b);
    return {17'h0, 8'(a), 8'(b)};
  endfunction : pair
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check("read data", exp_q.pop_front(), {pslverr, prdata});
    end
  end
  initial begin
    void'($urandom(32'h2906));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CLSP_CTRL_OFS, {1'b0, `CLSP_CTRL_RST});
    rd(`CLSP_GAIN_OFS, {1'b0, `CLSP_GAIN_RST});
    rd(12'h7fc, 33'h1_0000_0000);
    $display("test registers done");
    apb(1'b1, `CLSP_GAIN_OFS, 32'h10_0000);
    apb(1'b1, `CLSP_CTRL_OFS, 32'h5);
    repeat (4) begin
      cmd = $urandom_range(120) - 60;
      sp = $urandom_range(120) - 60;
      fa <= 8'(sp);
      fb <= 8'(-sp);
      apb(1'b1, `CLSP_CMD_OFS, {16'h0, 8'(cmd), 8'(-cmd)});
      ticks(2);
      rd(`CLSP_PWR_OFS, pair(cmd - sp, sp - cmd));
    end
    fa <= -8'sd100;
    fb <= 8'sd100;
    apb(1'b1, `CLSP_CMD_OFS, 32'h64_9c);
    ticks(2);
    rd(`CLSP_PWR_OFS, pair(127, -127));
    $display("test proportional done");
    apb(1'b1, `CLSP_GAIN_OFS, 32'h10);
    fa <= 8'sd0;
    fb <= 8'sd0;
    apb(1'b1, `CLSP_CMD_OFS, 32'h0);
    ticks(2);
    rd(`CLSP_PWR_OFS, pair(0, 0));
    apb(1'b1, `CLSP_CMD_OFS, 32'h0a_fb);
    ticks(1);
    rd(`CLSP_PWR_OFS, pair(10, -5));
    ticks(1);
    rd(`CLSP_PWR_OFS, pair(0, 0));
    $display("test differential done");
    apb(1'b1, `CLSP_CTRL_OFS, 32'h1);
    foreach (sv[i]) begin
      fa <= 8'(sv[i]);
      fb <= 8'(-sv[i]);
      ticks(2);
      rd(`CLSP_SPD_OFS, pair(sv[i], -sv[i]));
    end
    $display("test analog done");
    apb(1'b1, `CLSP_CTRL_OFS, 32'h0);
    ticks(1);
    check("drive off", 33'h0, {16'h0, drive_en, power_a, power_b});
    apb(1'b1, `CLSP_GAIN_OFS, 32'h7f00);
    apb(1'b1, `CLSP_CMD_OFS, 32'h64_64);
    apb(1'b1, `CLSP_CTRL_OFS, 32'h1);
    ticks(1);
    rd(`CLSP_PWR_OFS, pair(49, 49));
    ticks(29);
    rd(`CLSP_PWR_OFS, pair(127, 127));
    $display("test integral done");
    estop <= 1'b1;
    @(posedge pclk);
    check("stop outputs", 33'h0, {16'h0, drive_en, power_a, power_b});
    ticks(1);
    rd(`CLSP_PWR_OFS, 33'h1_0000);
    estop <= 1'b0;
    $display("test stop done");
    fa <= 8'sd5;
    fb <= 8'sd7;
    foreach (mexp[m]) begin
      apb(1'b1, `CLSP_CTRL_OFS, 32'h7 | (m << 4));
      apb(1'b1, `CLSP_CMD_OFS, 32'h1e_0a);
      ticks(2);
      check("open power", {17'h0, mexp[m]}, {17'h0, power_a, power_b});
    end
    apb(1'b1, `CLSP_SPD_OFS, 32'hffff_ffff);
    rd(`CLSP_SPD_OFS, pair(5, 7));
    $display("test open loop done");
    apb(1'b1, `CLSP_GAIN_OFS, 32'h10_0000);
    foreach (cexp[m]) begin
      apb(1'b1, `CLSP_CTRL_OFS, 32'h5 | (m << 4));
      ticks(2);
      check("closed power", {17'h0, cexp[m]}, {17'h0, power_a, power_b});
    end
    $display("test closed modes done");
    stop_test();
  end
endmodule : tb_top
